/* src/quad_dac_pkg.sv */
package quad_dac_pkg;

   ////////////////////////////////////////////////////////////////////////
   // serial word layout, first bit shifted in ends up at the top
   localparam int SHIFT_BITS = 16;
   localparam int ADDR_BITS = 4;
   localparam int CODE_BITS = 10;
   localparam int PAD_BITS = 2;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int CODE_MSB = 11;
   localparam int CODE_LSB = 2;
   localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // channels and codes
   localparam int NUM_CHANNELS = 4;
   // ideal output is code / CODE_SCALE times the reference
   localparam int CODE_SCALE = 1024;
   localparam logic [CODE_BITS-1:0] CODE_ZERO = 10'h000;
   localparam logic [CODE_BITS-1:0] CODE_FULL = 10'h3ff;
   localparam int FIFO_DEPTH = 8;

   ////////////////////////////////////////////////////////////////////////
   // address and control field values
   localparam logic [ADDR_BITS-1:0] ADDR_NOP = 4'h0;
   localparam logic [ADDR_BITS-1:0] ADDR_CH_A = 4'h1;
   localparam logic [ADDR_BITS-1:0] ADDR_CH_B = 4'h2;
   localparam logic [ADDR_BITS-1:0] ADDR_CH_C = 4'h3;
   localparam logic [ADDR_BITS-1:0] ADDR_CH_D = 4'h4;
   localparam logic [ADDR_BITS-1:0] ADDR_SLEEP = 4'he;
   localparam logic [ADDR_BITS-1:0] ADDR_ALL = 4'hf;
   localparam logic [NUM_CHANNELS-1:0] MASK_NONE = 4'h0;
   localparam logic [NUM_CHANNELS-1:0] MASK_ALL = 4'hf;

   ////////////////////////////////////////////////////////////////////////
   // carriers and states
   typedef logic [CODE_BITS-1:0] code_t;
   typedef code_t [NUM_CHANNELS-1:0] code_bank_t;

   typedef struct packed {
      logic [ADDR_BITS-1:0] word_address_field;
      code_t input_code_field;
   } load_word_t;

   typedef struct packed {
      logic [SHIFT_BITS-1:0] shift;
   } link_state_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HOLD = 2'b10
   } load_state_t;

endpackage

/* src/quad_dac_serial_load.sv */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// word queue between load capture and channel update
module quad_dac_fifo
#(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
)
(
   // clock, reset and flush
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [CW-1:0] count;
   } fifo_state_t;

   fifo_state_t st_reg;
   fifo_state_t st_next;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (st_reg.count != CW'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data = st_reg.mem[st_reg.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = next_ptr(st_reg.wr);
      end
      if (pop)
         st_next.rd = next_ptr(st_reg.rd);
      case ({push, pop})
         2'b10: st_next.count = st_reg.count + 1'b1;
         2'b01: st_next.count = st_reg.count - 1'b1;
         default: st_next.count = st_reg.count;
      endcase
      // flush drops queued words but leaves storage contents alone
      if (flush)
      begin
         st_next.rd = '0;
         st_next.wr = '0;
         st_next.count = '0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

endmodule

////////////////////////////////////////////////////////////////////////////
// serial front end of the quad converter
module quad_dac_serial_load
   import quad_dac_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
)
(
   // core clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // serial link
   input wire logic shift_clk,
   input wire logic serial_in,
   input wire logic select_load_strobe_n,
   input wire logic async_clear_n,
   output logic serial_out,
   // converter side
   input wire logic update_hold,
   output code_bank_t analog_outputs_a_to_d,
   output logic sleep_mode,
   output logic load_dropped
);

   typedef struct packed {
      logic clr_s1;
      logic clr_s2;
      logic clr_d;
      logic ld_s1;
      logic ld_s2;
      logic ld_d;
      load_state_t state;
      load_word_t held;
      code_bank_t codes;
      logic sleep;
      logic dropped;
   } core_state_t;

   link_state_t link_reg;
   link_state_t link_next;
   core_state_t core_reg;
   core_state_t core_next;
   logic link_rst;
   load_word_t link_word;
   logic clr_fall;
   logic ld_rise;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   load_word_t fifo_out_data;
   logic apply_fire;
   logic [NUM_CHANNELS-1:0] apply_mask;

   function automatic logic [NUM_CHANNELS-1:0] channel_mask(
      input logic [ADDR_BITS-1:0] addr);
      logic [NUM_CHANNELS-1:0] m;
      m = MASK_NONE;
      case (addr)
         ADDR_CH_A: m = 4'h1;
         ADDR_CH_B: m = 4'h2;
         ADDR_CH_C: m = 4'h4;
         ADDR_CH_D: m = 4'h8;
         ADDR_ALL: m = MASK_ALL;
         default: m = MASK_NONE;
      endcase
      return m;
   endfunction

   /////////////////////////////////////////////////////////////////////////
   // link domain: shift register on the serial clock
   // clear acts without any clock edge
   assign link_rst = rst | ~async_clear_n;

   always_comb
   begin
      link_next = link_reg;
      // host parks the clock low before the strobe falls, no stray edge
      if (!select_load_strobe_n)
         link_next.shift = {link_reg.shift[SHIFT_BITS-2:0], serial_in};
   end

   always_ff @(posedge shift_clk or posedge link_rst)
   begin
      if (link_rst)
         link_reg.shift <= SHIFT_RESET;
      else
         link_reg <= link_next;
   end

   // top bit went in sixteen edges ago
   assign serial_out = link_reg.shift[SHIFT_BITS-1];

   // pads in the low two bits are dropped
   assign link_word.word_address_field =
      link_reg.shift[ADDR_MSB:ADDR_LSB];
   assign link_word.input_code_field =
      link_reg.shift[CODE_MSB:CODE_LSB];

   /////////////////////////////////////////////////////////////////////////
   // core domain: edge detection, capture and channel update
   // word is quiet while the strobe is high, so capture after sync is safe
   assign clr_fall = core_reg.clr_d & ~core_reg.clr_s2;
   assign ld_rise = ~core_reg.ld_d & core_reg.ld_s2;
   assign fifo_in_valid = (core_reg.state == ST_HOLD);
   assign fifo_out_ready = ~update_hold & ~clr_fall;
   assign apply_fire = fifo_out_valid & fifo_out_ready;
   assign apply_mask = channel_mask(fifo_out_data.word_address_field);

   always_comb
   begin
      core_next = core_reg;
      core_next.clr_s1 = async_clear_n;
      core_next.clr_s2 = core_reg.clr_s1;
      core_next.clr_d = core_reg.clr_s2;
      core_next.ld_s1 = select_load_strobe_n;
      core_next.ld_s2 = core_reg.ld_s1;
      core_next.ld_d = core_reg.ld_s2;
      core_next.dropped = 1'b0;
      case (core_reg.state)
         ST_IDLE:
         begin
            if (ld_rise)
            begin
               core_next.held = link_word;
               core_next.state = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            // queue full stalls the capture; a further load is lost
            if (fifo_in_ready)
            begin
               core_next.state = ST_IDLE;
               if (ld_rise)
               begin
                  core_next.held = link_word;
                  core_next.state = ST_HOLD;
               end
            end
            else if (ld_rise)
               core_next.dropped = 1'b1;
         end
         default: core_next.state = ST_IDLE;
      endcase
      if (apply_fire)
      begin
         for (int i = 0; i < NUM_CHANNELS; i++)
            if (apply_mask[i])
               core_next.codes[i] = fifo_out_data.input_code_field;
         // sleep keeps codes; any other address wakes
         core_next.sleep = (fifo_out_data.word_address_field
                            == ADDR_SLEEP);
      end
      // clear overrides a load in the same cycle
      if (clr_fall)
      begin
         for (int i = 0; i < NUM_CHANNELS; i++)
            core_next.codes[i] = CODE_ZERO;
         core_next.state = ST_IDLE;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         core_reg <= '0;
         core_reg.clr_s1 <= 1'b1;
         core_reg.clr_s2 <= 1'b1;
         core_reg.clr_d <= 1'b1;
         core_reg.ld_s1 <= 1'b1;
         core_reg.ld_s2 <= 1'b1;
         core_reg.ld_d <= 1'b1;
         core_reg.state <= ST_IDLE;
         core_reg.codes <= '0;
      end
      else
         core_reg <= core_next;
   end

   quad_dac_fifo #(
      .WIDTH($bits(load_word_t)),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clk(core_clk),
      .rst(rst),
      .flush(clr_fall),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(core_reg.held),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // each code is a plain unsigned binary fraction of the reference
   assign analog_outputs_a_to_d = core_reg.codes;
   assign sleep_mode = core_reg.sleep;
   assign load_dropped = core_reg.dropped;

   /////////////////////////////////////////////////////////////////////////
   // checks
   property p_hold_when_high;
      @(posedge shift_clk) disable iff (link_rst)
      select_load_strobe_n |=> $stable(link_reg.shift);
   endproperty
   a_hold_when_high: assert property (p_hold_when_high)
      else $error("shift register moved while strobe high");
   property p_capture_bit;
      @(posedge shift_clk) disable iff (link_rst)
      !select_load_strobe_n |=> link_reg.shift[0] == $past(serial_in);
   endproperty
   a_capture_bit: assert property (p_capture_bit)
      else $error("serial input bit not captured");
   property p_cascade;
      @(posedge shift_clk) disable iff (link_rst)
      !select_load_strobe_n |=>
         serial_out == $past(link_reg.shift[SHIFT_BITS-2]);
   endproperty
   a_cascade: assert property (p_cascade)
      else $error("serial output not fed from shift chain");
   property p_clear_zero;
      @(posedge core_clk) disable iff (rst)
      clr_fall |=> analog_outputs_a_to_d == '0 ##1
         (analog_outputs_a_to_d == '0 || $past(apply_fire));
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("clear did not zero the channels");
   property p_capture_load;
      @(posedge core_clk) disable iff (rst)
      (ld_rise && core_reg.state == ST_IDLE && !clr_fall) |=>
         core_reg.state == ST_HOLD && core_reg.held == $past(link_word);
   endproperty
   a_capture_load: assert property (p_capture_load)
      else $error("load edge not captured");
   property p_single_load;
      @(posedge core_clk) disable iff (rst)
      (apply_fire && fifo_out_data.word_address_field == ADDR_CH_C) |=>
         analog_outputs_a_to_d[2] == $past(fifo_out_data.input_code_field)
         && analog_outputs_a_to_d[1] == $past(analog_outputs_a_to_d[1]);
   endproperty
   a_single_load: assert property (p_single_load)
      else $error("single channel load wrong");
   property p_all_load;
      @(posedge core_clk) disable iff (rst)
      (apply_fire && fifo_out_data.word_address_field == ADDR_ALL) |=>
         analog_outputs_a_to_d[0] == analog_outputs_a_to_d[3] &&
         analog_outputs_a_to_d[0] == $past(fifo_out_data.input_code_field);
   endproperty
   a_all_load: assert property (p_all_load)
      else $error("broadcast load wrong");
   property p_no_change;
      @(posedge core_clk) disable iff (rst)
      (apply_fire && apply_mask == MASK_NONE) |=>
         $stable(analog_outputs_a_to_d);
   endproperty
   a_no_change: assert property (p_no_change)
      else $error("no-change address altered a channel");
   property p_sleep_wake;
      @(posedge core_clk) disable iff (rst)
      apply_fire |=> sleep_mode ==
         ($past(fifo_out_data.word_address_field) == ADDR_SLEEP);
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("sleep state not set by load address");

endmodule

/* verif/quad_dac_host_model.sv */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// host side of the serial link; link clock runs inside frames, and outside them only in stray_clocks
module quad_dac_host_model
(
   // serial link
   output logic shift_clk,
   output logic serial_in,
   output logic select_load_strobe_n
);
   int half_ns = 6;

   initial
   begin
      shift_clk = 1'b0;
      serial_in = 1'b1;
      select_load_strobe_n = 1'b1;
   end

   // shift n bits first bit first, then raise the strobe to load
   task automatic send_bits(input logic [31:0] bits, input int n);
      shift_clk <= 1'b0;
      #(half_ns);
      select_load_strobe_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in <= bits[i];
         #(half_ns);
         shift_clk <= 1'b1;
         #(half_ns);
         shift_clk <= 1'b0;
      end
      #(half_ns);
      select_load_strobe_n <= 1'b1;
      // released data line must not keep its last value
      serial_in <= ~bits[0];
      #(8 * half_ns);
   endtask

   // pad bits sent high so the device must ignore them
   task automatic send_word(input logic [3:0] addr, input logic [9:0] code);
      send_bits({16'h0000, addr, code, 2'b11}, 16);
   endtask

   // clock pulses while the strobe is high
   task automatic stray_clocks(input int n);
      repeat (n)
      begin
         serial_in <= ~serial_in;
         #(half_ns);
         shift_clk <= 1'b1;
         #(half_ns);
         shift_clk <= 1'b0;
      end
   endtask
endmodule

/* verif/quad_dac_serial_load_tb_top.sv */
`timescale 1ns/100ps

module quad_dac_serial_load_tb_top;
   import quad_dac_pkg::*;

   logic core_clk;
   logic rst;
   logic async_clear_n;
   logic update_hold;
   logic shift_clk;
   logic serial_in;
   logic select_load_strobe_n;
   logic serial_out;
   code_bank_t analog_outputs_a_to_d;
   logic sleep_mode;
   logic load_dropped;
   logic drop_seen;
   code_bank_t exp_bank;
   int err_count = 0;
   int n_compared = 0;

   quad_dac_serial_load dut_u
   (
      .core_clk(core_clk),
      .rst(rst),
      .shift_clk(shift_clk),
      .serial_in(serial_in),
      .select_load_strobe_n(select_load_strobe_n),
      .async_clear_n(async_clear_n),
      .serial_out(serial_out),
      .update_hold(update_hold),
      .analog_outputs_a_to_d(analog_outputs_a_to_d),
      .sleep_mode(sleep_mode),
      .load_dropped(load_dropped)
   );

   quad_dac_host_model host_u
   (
      .shift_clk(shift_clk),
      .serial_in(serial_in),
      .select_load_strobe_n(select_load_strobe_n)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         drop_seen <= 1'b0;
      else if (load_dropped === 1'b1)
         drop_seen <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // checking helpers
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic load(input logic [3:0] addr, input logic [9:0] code);
      host_u.send_word(addr, code);
      settle(12);
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset();
      chk(64'(analog_outputs_a_to_d), 64'h0);
      chk(64'(sleep_mode), 64'h0);
      chk(64'(serial_out), 64'h0);
   endtask

   task automatic test_channels();
      code_t codes[4] = '{CODE_FULL, 10'h001, 10'h2aa, 10'h155};
      for (int c = 0; c < NUM_CHANNELS; c++)
      begin
         load(4'(c + 1), codes[c]);
         exp_bank[c] = codes[c];
         chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      end
   endtask

   task automatic test_all_none();
      load(ADDR_ALL, 10'h0f0);
      exp_bank = {4{10'h0f0}};
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      load(ADDR_NOP, CODE_FULL);
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      for (int a = 5; a <= 13; a++)
      begin
         load(4'(a), 10'h3c3);
         chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      end
   endtask

   task automatic test_sleep();
      load(ADDR_SLEEP, CODE_FULL);
      chk(64'(sleep_mode), 64'h1);
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      load(ADDR_CH_B, 10'h123);
      exp_bank[1] = 10'h123;
      chk(64'(sleep_mode), 64'h0);
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      load(ADDR_SLEEP, 10'h000);
      load(ADDR_NOP, 10'h000);
      chk(64'(sleep_mode), 64'h0);
   endtask

   // two words in one frame; only the last one loads, and serial_out
   // then shows the top address bit of the second word
   task automatic test_cascade();
      host_u.send_bits({ADDR_CH_A, 10'h2d2, 2'b11, ADDR_ALL, 10'h0a5, 2'b11},
                       32);
      settle(12);
      exp_bank = {4{10'h0a5}};
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      chk(64'(serial_out), 64'h1);
      // a shift here would bring code bit 9 (zero) to the output
      host_u.stray_clocks(4);
      settle(12);
      chk(64'(serial_out), 64'h1);
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
   endtask

   task automatic test_fifo();
      @(posedge core_clk) update_hold <= 1'b1;
      for (int i = 1; i <= 10; i++)
         host_u.send_word(ADDR_CH_A, 10'(i));
      settle(12);
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
      chk(64'(drop_seen), 64'h1);
      @(posedge core_clk) update_hold <= 1'b0;
      settle(30);
      exp_bank[0] = 10'h009;
      chk(64'(analog_outputs_a_to_d), 64'(exp_bank));
   endtask

   task automatic test_clear();
      @(posedge core_clk) update_hold <= 1'b1;
      load(ADDR_CH_B, 10'h111);
      host_u.send_bits({16'h0000, 16'hffff}, 32);
      @(posedge core_clk) async_clear_n <= 1'b0;
      settle(3);
      chk(64'(serial_out), 64'h0);
      @(posedge core_clk) async_clear_n <= 1'b1;
      update_hold <= 1'b0;
      settle(20);
      chk(64'(analog_outputs_a_to_d), 64'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial
   begin
      // non-blocking so the reset edge reaches every process at time zero
      rst <= 1'b1;
      async_clear_n <= 1'b1;
      update_hold <= 1'b0;
      exp_bank = '0;
      settle(6);
      rst <= 1'b0;
      settle(4);
      test_reset();
      test_channels();
      test_all_none();
      test_sleep();
      test_cascade();
      test_fifo();
      test_clear();
      summarize();
   end

   initial
   begin
      #400000;
      err_count++;
      summarize();
   end
endmodule
